// ==== verilog/boot_tap_pkg.sv ====
/*
  Constants, encodings and state records shared by the serial boot port,
  the software terminal, the timeout monitor and the scan port.
  Assumes a 10 MHz core clock and a test clock far slower than it.
*/
package boot_tap_pkg;

  localparam int          CLK_HZ         = 10_000_000;
  localparam int          LINE_BITS      = 193;
  localparam int          COUNT_W        = 10;
  localparam int          SLOW_PERIOD    = 256;
  localparam int          FAST_PERIOD    = 16;
  localparam logic [7:0]  HALF_SLOW_LAST = 8'(SLOW_PERIOD / 2 - 1);
  localparam logic [7:0]  HALF_FAST_LAST = 8'(FAST_PERIOD / 2 - 1);
  localparam logic [7:0]  COUNT_LAST     = 8'(COUNT_W - 1);
  localparam logic [7:0]  LINE_LAST      = 8'(LINE_BITS - 1);
  localparam int          IDLE_LIMIT     = 2048;
  localparam logic [11:0] IDLE_LAST      = 12'(IDLE_LIMIT - 1);
  localparam logic [1:0]  STAT_PULSE     = 2'h3;

  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam int          CTRL_XMIT      = 0;
  localparam int          STAT_RCV       = 0;
  localparam int          STAT_DONE      = 1;
  localparam int          STAT_FAST      = 2;
  localparam int          STAT_XMIT      = 3;
  localparam int          STAT_IR_LO     = 8;

  localparam int          SY_SIN         = 0;
  localparam int          SY_TDI         = 1;
  localparam int          SY_TMS         = 2;
  localparam int          SY_TCK         = 3;

  localparam logic [4:0]  IR_SAMPLE      = 5'h18;
  localparam logic [4:0]  IR_HIGHZ       = 5'h19;
  localparam logic [4:0]  IR_CLAMP       = 5'h1a;
  localparam logic [4:0]  IR_EXTEST      = 5'h1b;
  localparam logic [4:0]  IR_BYPASS      = 5'h1f;
  localparam logic [4:0]  IR_CAPTURE     = 5'h01;

  typedef enum logic [1:0] {BOOT_STRAP, BOOT_COUNT, BOOT_LINES, BOOT_DONE} boot_phase_t;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAUSE_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic [3:0]           sync1;
    logic [3:0]           sync2;
    logic                 tck_prev;
    boot_phase_t          phase;
    logic                 fast;
    logic [7:0]           div_cnt;
    logic                 sclk;
    logic [7:0]           bit_cnt;
    logic [COUNT_W-1:0]   line_cnt;
    logic [LINE_BITS-1:0] shift;
    logic                 xmit_pend;
    logic                 xmit;
    logic                 rcv_prev;
    logic                 trap;
    logic [11:0]          idle_cnt;
    logic [1:0]           stat_cnt;
    logic                 f_en_n;
    logic                 f_sclk;
    logic                 f_stat;
    logic                 pin_en_n;
    logic                 pin_sclk;
    logic                 pin_stat;
    logic                 pins_oe_n;
    logic                 tdo;
    logic                 tdo_oe_n;
    logic [31:0]          rdata;
  } core_t;

  typedef struct packed {
    tap_state_t state;
    logic [4:0] ir;
    logic [4:0] ir_shift;
    logic       byp;
    logic [3:0] bsr_shift;
    logic [2:0] bsr_upd;
  } tap_regs_t;

endpackage : boot_tap_pkg

// ==== verilog/test_access_and_serial_boot_port.sv ====
/*
  Serial boot loader, software serial terminal, retire timeout monitor and
  boundary-scan test access port in one module.
  Assumes: boot and scan pins are asynchronous to clk and far slower than it;
  retire and privileged-mode inputs come from core logic on clk.
*/
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps
module test_access_and_serial_boot_port #(
  parameter int LINES = 1024
) (
  input  wire logic                                clk,
  input  wire logic                                arst_n,
  input  wire logic                                clk_en,
  input  wire logic                                fast_boot_load_flag,
  input  wire logic                                priv_write_retired,
  input  wire logic                                instr_retired,
  input  wire logic                                privileged_code_mode,
  input  wire logic [boot_tap_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [31:0]                         reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic      [31:0]                         reg_rdata,
  input  wire logic                                boot_rom_serial_in,
  output logic                                     boot_rom_enable_n,
  output logic                                     boot_rom_shift_clock,
  output logic                                     test_status_out,
  output logic                                     boot_pins_oe_n,
  output logic                                     serial_trap,
  input  wire logic                                tck,
  input  wire logic                                tms,
  input  wire logic                                tdi,
  input  wire logic                                trst_n,
  output logic                                     tdo,
  output logic                                     tdo_oe_n,
  input  wire logic [$clog2(LINES)-1:0]            fetch_idx,
  output logic      [boot_tap_pkg::LINE_BITS-1:0]  fetch_data
);

  localparam int IDX_W = $clog2(LINES);

  boot_tap_pkg::core_t                      st, n;
  boot_tap_pkg::tap_regs_t                  tp, tn;
  logic                                     sample;
  logic                                     rise;
  logic                                     fall;
  logic                                     cache_we;
  logic [IDX_W-1:0]                         cache_idx;
  logic [boot_tap_pkg::LINE_BITS-1:0]       cache_wdata;
  logic [boot_tap_pkg::COUNT_W-1:0]         cnt_in;
  logic                                     tap_rst_n;
  logic [boot_tap_pkg::LINE_BITS-1:0]       cache_mem [LINES];

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] half_last(input logic fast);
    return fast ? boot_tap_pkg::HALF_FAST_LAST : boot_tap_pkg::HALF_SLOW_LAST;
  endfunction : half_last

  // private codes fall back to the bypass path; loading them is the tester's fault
  function automatic logic sel_bsr(input logic [4:0] ir);
    return (ir == boot_tap_pkg::IR_SAMPLE) || (ir == boot_tap_pkg::IR_EXTEST);
  endfunction : sel_bsr

  function automatic boot_tap_pkg::tap_state_t tap_next(input boot_tap_pkg::tap_state_t s, input logic m);
    unique case (s)
      boot_tap_pkg::TAP_RESET:    return m ? boot_tap_pkg::TAP_RESET  : boot_tap_pkg::TAP_IDLE;
      boot_tap_pkg::TAP_IDLE:     return m ? boot_tap_pkg::TAP_SEL_DR : boot_tap_pkg::TAP_IDLE;
      boot_tap_pkg::TAP_SEL_DR:   return m ? boot_tap_pkg::TAP_SEL_IR : boot_tap_pkg::TAP_CAP_DR;
      boot_tap_pkg::TAP_CAP_DR:   return m ? boot_tap_pkg::TAP_EX1_DR : boot_tap_pkg::TAP_SH_DR;
      boot_tap_pkg::TAP_SH_DR:    return m ? boot_tap_pkg::TAP_EX1_DR : boot_tap_pkg::TAP_SH_DR;
      boot_tap_pkg::TAP_EX1_DR:   return m ? boot_tap_pkg::TAP_UPD_DR : boot_tap_pkg::TAP_PAUSE_DR;
      boot_tap_pkg::TAP_PAUSE_DR: return m ? boot_tap_pkg::TAP_EX2_DR : boot_tap_pkg::TAP_PAUSE_DR;
      boot_tap_pkg::TAP_EX2_DR:   return m ? boot_tap_pkg::TAP_UPD_DR : boot_tap_pkg::TAP_SH_DR;
      boot_tap_pkg::TAP_UPD_DR:   return m ? boot_tap_pkg::TAP_SEL_DR : boot_tap_pkg::TAP_IDLE;
      boot_tap_pkg::TAP_SEL_IR:   return m ? boot_tap_pkg::TAP_RESET  : boot_tap_pkg::TAP_CAP_IR;
      boot_tap_pkg::TAP_CAP_IR:   return m ? boot_tap_pkg::TAP_EX1_IR : boot_tap_pkg::TAP_SH_IR;
      boot_tap_pkg::TAP_SH_IR:    return m ? boot_tap_pkg::TAP_EX1_IR : boot_tap_pkg::TAP_SH_IR;
      boot_tap_pkg::TAP_EX1_IR:   return m ? boot_tap_pkg::TAP_UPD_IR : boot_tap_pkg::TAP_PAUSE_IR;
      boot_tap_pkg::TAP_PAUSE_IR: return m ? boot_tap_pkg::TAP_EX2_IR : boot_tap_pkg::TAP_PAUSE_IR;
      boot_tap_pkg::TAP_EX2_IR:   return m ? boot_tap_pkg::TAP_UPD_IR : boot_tap_pkg::TAP_SH_IR;
      boot_tap_pkg::TAP_UPD_IR:   return m ? boot_tap_pkg::TAP_SEL_DR : boot_tap_pkg::TAP_IDLE;
    endcase
  endfunction : tap_next

  ////////////////////////////////////////////////////////////////////////////
  // test reset acts straight from the pin so it forces the tap even without tck
  assign tap_rst_n = arst_n & trst_n;

  always_comb begin
    n           = st;
    tn          = tp;
    cache_we    = 1'b0;
    cache_idx   = st.line_cnt[IDX_W-1:0];
    cache_wdata = {st.shift[boot_tap_pkg::LINE_BITS-2:0], st.sync2[boot_tap_pkg::SY_SIN]};
    cnt_in      = {st.shift[boot_tap_pkg::COUNT_W-2:0], st.sync2[boot_tap_pkg::SY_SIN]};
    sample      = 1'b0;
    // pins are taken as driven; any termination lives on the board
    n.sync1     = {tck, tms, tdi, boot_rom_serial_in};
    n.sync2     = st.sync1;
    n.tck_prev  = st.sync2[boot_tap_pkg::SY_TCK];
    n.trap      = 1'b0;
    n.rdata     = '0;

    // shift clock: 50% duty, sample on its rising edge
    if (st.phase inside {boot_tap_pkg::BOOT_COUNT, boot_tap_pkg::BOOT_LINES}) begin
      if (st.div_cnt == half_last(st.fast)) begin
        n.div_cnt = '0;
        n.sclk    = ~st.sclk;
        sample    = ~st.sclk;
      end else begin
        n.div_cnt = st.div_cnt + 8'h01;
      end
    end
    if (sample) begin
      n.shift = cache_wdata;
    end

    unique case (st.phase)
      boot_tap_pkg::BOOT_STRAP: begin
        n.fast  = fast_boot_load_flag;
        n.phase = boot_tap_pkg::BOOT_COUNT;
      end
      boot_tap_pkg::BOOT_COUNT: begin
        if (sample) begin
          if (st.bit_cnt == boot_tap_pkg::COUNT_LAST) begin
            n.bit_cnt  = '0;
            // lines arrive highest index first
            n.line_cnt = cnt_in - 10'h001;
            if (cnt_in == '0) begin
              n.phase = boot_tap_pkg::BOOT_DONE;
              n.sclk  = 1'b0;
            end else begin
              n.phase = boot_tap_pkg::BOOT_LINES;
            end
          end else begin
            n.bit_cnt = st.bit_cnt + 8'h01;
          end
        end
      end
      boot_tap_pkg::BOOT_LINES: begin
        if (sample) begin
          if (st.bit_cnt == boot_tap_pkg::LINE_LAST) begin
            cache_we  = 1'b1;
            n.bit_cnt = '0;
            if (st.line_cnt == '0) begin
              n.phase = boot_tap_pkg::BOOT_DONE;
              n.sclk  = 1'b0;
            end else begin
              n.line_cnt = st.line_cnt - 10'h001;
            end
          end else begin
            n.bit_cnt = st.bit_cnt + 8'h01;
          end
        end
      end
      boot_tap_pkg::BOOT_DONE: begin
        // receive side: any level change traps unless privileged code runs
        n.rcv_prev = st.sync2[boot_tap_pkg::SY_SIN];
        n.trap     = (st.rcv_prev != st.sync2[boot_tap_pkg::SY_SIN]) && !privileged_code_mode;
        if (st.stat_cnt != '0) begin
          n.stat_cnt = st.stat_cnt - 2'h1;
        end
        if (instr_retired) begin
          n.idle_cnt = '0;
        end else if (st.idle_cnt == boot_tap_pkg::IDLE_LAST) begin
          n.idle_cnt = '0;
          n.stat_cnt = boot_tap_pkg::STAT_PULSE;
        end else begin
          n.idle_cnt = st.idle_cnt + 12'h001;
        end
      end
    endcase

    // software transmit bit: staged by the write, shown once the write retires
    if (reg_wr && reg_addr == boot_tap_pkg::ADDR_CTRL) begin
      n.xmit_pend = reg_wdata[boot_tap_pkg::CTRL_XMIT];
    end
    if (priv_write_retired) begin
      n.xmit = st.xmit_pend;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        boot_tap_pkg::ADDR_CTRL: begin
          n.rdata[boot_tap_pkg::CTRL_XMIT] = st.xmit_pend;
        end
        boot_tap_pkg::ADDR_STATUS: begin
          n.rdata[boot_tap_pkg::STAT_RCV]  = st.sync2[boot_tap_pkg::SY_SIN];
          n.rdata[boot_tap_pkg::STAT_DONE] = st.phase == boot_tap_pkg::BOOT_DONE;
          n.rdata[boot_tap_pkg::STAT_FAST] = st.fast;
          n.rdata[boot_tap_pkg::STAT_XMIT] = st.xmit;
          n.rdata[boot_tap_pkg::STAT_IR_LO +: 5] = tp.ir;
        end
        default: begin
          n.rdata = '0;
        end
      endcase
    end

    n.f_en_n = !(n.phase inside {boot_tap_pkg::BOOT_COUNT, boot_tap_pkg::BOOT_LINES});
    n.f_sclk = (n.phase == boot_tap_pkg::BOOT_DONE) ? n.xmit : n.sclk;
    n.f_stat = n.stat_cnt != '0;

    ////////////////////////////////////////////////////////////////////////////
    // scan port, stepped by edges of the sampled test clock
    rise = st.sync2[boot_tap_pkg::SY_TCK] & ~st.tck_prev;
    fall = ~st.sync2[boot_tap_pkg::SY_TCK] & st.tck_prev;
    if (rise) begin
      tn.state = tap_next(tp.state, st.sync2[boot_tap_pkg::SY_TMS]);
      unique case (tp.state)
        boot_tap_pkg::TAP_CAP_IR: tn.ir_shift = boot_tap_pkg::IR_CAPTURE;
        boot_tap_pkg::TAP_SH_IR:  tn.ir_shift = {st.sync2[boot_tap_pkg::SY_TDI], tp.ir_shift[4:1]};
        boot_tap_pkg::TAP_CAP_DR: begin
          tn.byp       = 1'b0;
          tn.bsr_shift = {st.sync2[boot_tap_pkg::SY_SIN], st.f_en_n, st.f_sclk, st.f_stat};
        end
        boot_tap_pkg::TAP_SH_DR: begin
          if (sel_bsr(tp.ir)) begin
            tn.bsr_shift = {st.sync2[boot_tap_pkg::SY_TDI], tp.bsr_shift[3:1]};
          end else begin
            tn.byp = st.sync2[boot_tap_pkg::SY_TDI];
          end
        end
        default: begin
          tn.byp = tp.byp;
        end
      endcase
    end
    if (fall) begin
      if (tp.state == boot_tap_pkg::TAP_UPD_IR) begin
        tn.ir = tp.ir_shift;
      end
      if (tp.state == boot_tap_pkg::TAP_UPD_DR && sel_bsr(tp.ir)) begin
        tn.bsr_upd = tp.bsr_shift[2:0];
      end
      n.tdo_oe_n = !(tp.state inside {boot_tap_pkg::TAP_SH_IR, boot_tap_pkg::TAP_SH_DR});
      if (tp.state == boot_tap_pkg::TAP_SH_IR) begin
        n.tdo = tp.ir_shift[0];
      end else if (tp.state == boot_tap_pkg::TAP_SH_DR) begin
        n.tdo = sel_bsr(tp.ir) ? tp.bsr_shift[0] : tp.byp;
      end else begin
        n.tdo = 1'b0;
      end
    end
    if (tp.state == boot_tap_pkg::TAP_RESET) begin
      tn.ir = boot_tap_pkg::IR_BYPASS;
    end

    // pin drivers: functional path unless a scan instruction owns the pins
    n.pins_oe_n = 1'b0;
    n.pin_en_n  = n.f_en_n;
    n.pin_sclk  = n.f_sclk;
    n.pin_stat  = n.f_stat;
    if (tp.ir == boot_tap_pkg::IR_EXTEST || tp.ir == boot_tap_pkg::IR_CLAMP) begin
      {n.pin_en_n, n.pin_sclk, n.pin_stat} = tp.bsr_upd;
    end
    if (tp.ir == boot_tap_pkg::IR_HIGHZ) begin
      n.pins_oe_n = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st           <= '0;
      st.f_en_n    <= 1'b1;
      st.pin_en_n  <= 1'b1;
      st.tdo_oe_n  <= 1'b1;
    end else if (clk_en) begin
      st <= n;
    end
  end

  always_ff @(posedge clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tp    <= '0;
      tp.ir <= boot_tap_pkg::IR_BYPASS;
    end else if (clk_en) begin
      tp <= tn;
    end
  end

  // cache array holds no reset; only the read register does
  always_ff @(posedge clk) begin
    if (clk_en && cache_we) begin
      cache_mem[cache_idx] <= cache_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_data <= '0;
    end else if (clk_en) begin
      fetch_data <= cache_mem[fetch_idx];
    end
  end

  assign reg_rdata            = st.rdata;
  assign boot_rom_enable_n    = st.pin_en_n;
  assign boot_rom_shift_clock = st.pin_sclk;
  assign test_status_out      = st.pin_stat;
  assign boot_pins_oe_n       = st.pins_oe_n;
  assign serial_trap          = st.trap;
  assign tdo                  = st.tdo;
  assign tdo_oe_n             = st.tdo_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence pulse_three;
    st.f_stat [*3] ##1 !st.f_stat;
  endsequence

  a_rom_enable_low: assert property (st.phase inside {boot_tap_pkg::BOOT_COUNT, boot_tap_pkg::BOOT_LINES} |=>
    !st.f_en_n || st.phase == boot_tap_pkg::BOOT_DONE) else $error("rom enable not low during load");
  a_rom_enable_done: assert property (st.phase == boot_tap_pkg::BOOT_DONE |=> st.f_en_n [*2])
    else $error("rom enable low after load");
  a_sclk_slow_period: assert property ($rose(st.sclk) && !st.fast |-> ##256
    ($rose(st.sclk) || st.phase == boot_tap_pkg::BOOT_DONE)) else $error("slow shift clock period wrong");
  a_sclk_fast_period: assert property ($rose(st.sclk) && st.fast |-> ##16
    ($rose(st.sclk) || st.phase == boot_tap_pkg::BOOT_DONE)) else $error("fast shift clock period wrong");
  a_sample_on_edge: assert property (sample && st.phase == boot_tap_pkg::BOOT_COUNT |=>
    st.shift[0] == $past(st.sync2[boot_tap_pkg::SY_SIN]) && ($rose(st.sclk) || st.phase == boot_tap_pkg::BOOT_DONE))
    else $error("rom bit not sampled");
  a_xmit_on_retire: assert property (!priv_write_retired |=> st.xmit == $past(st.xmit))
    else $error("transmit changed without retire");
  a_trap_native: assert property (st.phase == boot_tap_pkg::BOOT_DONE && !privileged_code_mode &&
    st.rcv_prev != st.sync2[boot_tap_pkg::SY_SIN] |=> st.trap) else $error("receive change did not trap");
  a_trap_blocked: assert property (privileged_code_mode |=> !st.trap) else $error("trap in privileged mode");
  a_timeout_pulse: assert property ($rose(st.f_stat) |-> pulse_three) else $error("status pulse not 3 cycles");
  a_bypass_path: assert property (rise && tp.state == boot_tap_pkg::TAP_SH_DR && !sel_bsr(tp.ir) |=>
    tp.byp == $past(st.sync2[boot_tap_pkg::SY_TDI])) else $error("bypass stage did not take tdi");
  a_tap_reset: assert property (@(posedge clk) disable iff (!arst_n) !trst_n |->
    tp.state == boot_tap_pkg::TAP_RESET && tp.ir == boot_tap_pkg::IR_BYPASS) else $error("tap not in reset");

endmodule : test_access_and_serial_boot_port

// ==== tb/boot_rom_model.sv ====
/*
  Serial boot ROM and terminal line driver on the far side of the boot pins.
  Assumes enable_n low selects the rom and high enables the terminal driver.
*/
`timescale 1ns/100ps
module boot_rom_model #(
  parameter int N = 396
) (
  input  wire logic         clk,
  input  wire logic         enable_n,
  input  wire logic         shift_clock,
  input  wire logic [N-1:0] rom_bits,
  input  wire logic         term_rx,
  output logic              data_out
);
  int   idx  = 0;
  logic sc_q = 1'b0;
  ////////////////////////////////////////
  // enable_n doubles as the rom reset
  always @(posedge clk) begin
    sc_q <= shift_clock;
    if (enable_n) begin
      idx <= 0;
    end else if (shift_clock && !sc_q) begin
      idx <= idx + 1;
    end
  end
  // past the last bit nothing real is driven, so show the inverse
  assign data_out = enable_n ? term_rx : (idx < N) ? rom_bits[idx] : ~rom_bits[N-1];
endmodule : boot_rom_model

// ==== tb/tb_top.sv ====
/*
  Bench for the boot and scan port: loads at both rates, terminal, timeout, scan codes.
  Assumes clk_en stays high and the scan clock is far slower than clk.
*/
`timescale 1ns/100ps
module tb_top;
  localparam int NB = 396;
  logic          clk, arst_n, fast, pwr, iret, pmode, wr, rd, sin, term_rx;
  logic          tck, tms, tdi, trst_n, en_n, sclk, stat, oe_n, trap, tdo, tdo_oe_n;
  logic [3:0]    addr;
  logic [31:0]   wdata, rdata, lfsr, v;
  logic [1:0]    fidx;
  logic [192:0]  fdata;
  logic [NB-1:0] rom;
  logic [7:0]    d;
  logic [4:0]    codes [5];
  logic [2:0]    latch;
  int            n_errors, cmp_count, cyc, n;
  test_access_and_serial_boot_port #(.LINES(4)) dut (
    .clk(clk), .arst_n(arst_n), .clk_en(1'b1), .fast_boot_load_flag(fast), .priv_write_retired(pwr),
    .instr_retired(iret), .privileged_code_mode(pmode), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .boot_rom_serial_in(sin), .boot_rom_enable_n(en_n),
    .boot_rom_shift_clock(sclk), .test_status_out(stat), .boot_pins_oe_n(oe_n), .serial_trap(trap),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .fetch_idx(fidx), .fetch_data(fdata));
  boot_rom_model #(.N(NB)) rom_m (.clk(clk), .enable_n(en_n), .shift_clock(sclk), .rom_bits(rom),
    .term_rx(term_rx), .data_out(sin));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // the first line streamed lands at the highest index, first bit on top
  function automatic logic [192:0] line_exp(input int cnt, input int li);
    logic [192:0] r;
    for (int j = 0; j < 193; j++) r[192-j] = rom[10 + (cnt - 1 - li) * 193 + j];
    return r;
  endfunction : line_exp
  task automatic chk(input logic [192:0] e, input logic [192:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] dv);
    @(posedge clk);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] dv);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 dv = rdata;
  endtask : rd_reg
  task automatic boot(input logic f, input logic [9:0] cnt);
    arst_n <= 1'b0;
    fast <= f;
    for (int k = 0; k < NB; k++) begin
      lfsr = lfsr_next(lfsr);
      rom[k] = (k < 10) ? cnt[9-k] : lfsr[0];
    end
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
  endtask : boot
  task automatic period(input int p);
    wait (sclk === 1'b1);
    n = 0;
    @(posedge clk);
    while (sclk === 1'b1) begin
      @(posedge clk);
      n++;
    end
    while (sclk === 1'b0) begin
      @(posedge clk);
      n++;
    end
    chk(p, n);
  endtask : period
  task automatic wait_done(input int lim);
    n = 0;
    while (en_n !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(1'b1, n < lim);
  endtask : wait_done
  // tms and tdi move with the falling test clock; tdo is read just before the next fall
  task automatic tstep(input logic m, input logic di, output logic o);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= di;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (3) @(posedge clk);
    o = tdo;
  endtask : tstep
  task automatic scan(input logic ir, input logic [7:0] din, input int len, output logic [7:0] dout);
    logic b;
    dout = '0;
    tstep(1'b1, 1'b0, b);
    if (ir) tstep(1'b1, 1'b0, b);
    tstep(1'b0, 1'b0, b);
    tstep(1'b0, 1'b0, b);
    for (int i = 0; i < len; i++) begin
      tstep(i == len - 1, din[i], b);
      dout[i] = b;
      if (i == 0) chk(1'b0, tdo_oe_n);
    end
    tstep(1'b1, 1'b0, b);
    tstep(1'b0, 1'b0, b);
  endtask : scan
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end
  initial begin
    {arst_n, fast, pwr, pmode, wr, rd, term_rx, tck, tdi, trst_n} = '0;
    {iret, tms} = 2'b11;
    {addr, wdata, fidx, n_errors, cmp_count} = '0;
    lfsr = 32'h0000_0004;
    // only public codes are ever loaded
    codes = '{boot_tap_pkg::IR_SAMPLE, boot_tap_pkg::IR_EXTEST, boot_tap_pkg::IR_CLAMP,
              boot_tap_pkg::IR_HIGHZ, boot_tap_pkg::IR_BYPASS};
    boot(1'b0, 10'h000);
    period(256);
    chk(1'b0, en_n);
    wait_done(2400);
    trst_n <= 1'b1;
    boot(1'b1, 10'h002);
    period(16);
    wait_done(6600);
    for (int i = 0; i < 2; i++) begin
      fidx <= 2'(i);
      repeat (2) @(posedge clk);
      #1 chk(line_exp(2, i), fdata);
    end
    chk(1'b0, sclk);
    lfsr = lfsr_next(lfsr);
    wr_reg(4'h0, {lfsr[31:1], 1'b1});
    repeat (3) @(posedge clk);
    #1 chk(1'b0, sclk);
    @(posedge clk);
    pwr <= 1'b1;
    @(posedge clk);
    pwr <= 1'b0;
    @(posedge clk);
    #1 chk(1'b1, sclk);
    rd_reg(4'h4, v);
    chk(32'h0000_1f0e | 32'(term_rx), v);
    rd_reg(4'h0, v);
    chk(32'h0000_0001, v);
    rd_reg(4'h8, v);
    chk(32'h0000_0000, v);
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      pmode <= m[0];
      term_rx <= ~term_rx;
      n = 0;
      repeat (10) begin
        @(posedge clk);
        n += (trap === 1'b1);
      end
      chk(m == 0, n);
    end
    iret <= 1'b0;
    n = 0;
    while (stat !== 1'b1 && n < 2200) begin
      @(posedge clk);
      n++;
    end
    chk(1'b1, n >= 2046 && n <= 2053);
    n = 0;
    while (stat === 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk(3, n);
    iret <= 1'b1;
    for (int i = 0; i < 6; i++) tstep(i < 5, 1'b0, d[0]);
    for (int k = 0; k < 5; k++) begin
      scan(1'b1, {3'h0, codes[k]}, 5, d);
      chk(boot_tap_pkg::IR_CAPTURE, d[4:0]);
      rd_reg(4'h4, v);
      chk(codes[k], v[12:8]);
      lfsr = lfsr_next(lfsr);
      scan(1'b0, lfsr[7:0], 8, d);
      if (k < 2) chk(lfsr[3:0], d[7:4]);
      else chk({lfsr[6:0], 1'b0}, d);
      if (k == 0) chk({term_rx, 3'b110}, d[3:0]);
      if (k == 1) latch = lfsr[6:4];
      repeat (8) @(posedge clk);
      #1 chk((k == 3) ? 5'h18 : (k == 1 || k == 2) ? {2'b10, latch} : 5'h16,
             {tdo_oe_n, oe_n, (k == 3) ? 3'h0 : {en_n, sclk, stat}});
    end
    end_of_test();
  end
endmodule : tb_top
